// ---- rtl/wct_pkg.sv ----
// Constants, types and register map of the waveform capture trigger.
package wct_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] WCT_CTRL_ADDR = 8'h00;
   localparam logic [7:0] WCT_LEVEL_ADDR = 8'h04;
   localparam logic [7:0] WCT_PRE_ADDR = 8'h08;
   localparam logic [7:0] WCT_DEPTH_ADDR = 8'h0c;
   localparam logic [7:0] WCT_STATUS_ADDR = 8'h10;
   localparam logic [7:0] WCT_STAMP_ADDR = 8'h14;
   localparam logic [7:0] WCT_CHEN_ADDR = 8'h18;
   localparam logic [7:0] WCT_FACT_ADDR = 8'h1c;
   // ****************************************
   // Control fields
   // ****************************************
   localparam int WCT_CTRL_START = 0;
   localparam int WCT_CTRL_STOP = 1;
   localparam int WCT_CTRL_SLOPE = 2;
   localparam int WCT_CTRL_AUTO = 3;
   localparam int WCT_CTRL_DSPEC = 4;
   localparam int WCT_CTRL_MULTI = 5;
   localparam int WCT_CTRL_SRC_LSB = 8;
   localparam int WCT_CTRL_MODE_LSB = 12;
   localparam int WCT_CTRL_TCH_LSB = 16;
   localparam logic [1:0] WCT_RESP_OKAY = 2'b00;
   localparam logic [1:0] WCT_RESP_SLVERR = 2'b10;
   // ****************************************
   // Sizes and timing
   // ****************************************
   localparam int WCT_PRE_DEPTH = 19200;
   localparam int WCT_REC_DEPTH = 480000;
   localparam int WCT_CLK_MHZ = 100;
   localparam int WCT_MUTE_MS = 3;
   localparam int WCT_MUTE_CYC = WCT_MUTE_MS * 1000 * WCT_CLK_MHZ;
   localparam logic [31:0] WCT_ZERO32 = 32'h0000_0000;
   localparam logic [31:0] WCT_ONE32 = 32'h0000_0001;

   typedef enum logic [2:0] {WCT_SRC_CH1, WCT_SRC_CH2, WCT_SRC_TCH, WCT_SRC_MAN, WCT_SRC_GEN} wct_src_t;
   typedef enum logic [1:0] {WCT_MODE_STD, WCT_MODE_PEAK, WCT_MODE_DEC} wct_mode_t;
   typedef enum logic [2:0] {WCT_IDLE, WCT_FILL, WCT_MUTE, WCT_WAIT, WCT_POST, WCT_DONE} wct_state_t;
endpackage

// ---- rtl/wct_trigger.sv ----
// Trigger, pre-event buffer and capture control with an AXI4-Lite register port.
// Overview of operation
// (RL1) Choosing inactive trigger channel activates it.
// (RL2) Decimated spectrum forces manual source.
// (RL3) Multichannel without trigger channel forces manual.
// (RL4) Channel sources fire on threshold crossing.
// (RL5) Manual source fires at measurement start.
// (RL6) Generator mutes, restart starts recording compensated.
// (RL7) Generator sync adds no filter settling.
// (RL8) Re-arm only after opposite crossing.
// (RL9) Rising fires above, re-arms below.
// (RL10) Falling fires below, re-arms above.
// (RL11) Zero pre-event interval disables buffer.
// (RL12) Pre-event buffer holds 19200 samples; the code sizes it by PRE_DEPTH, default 16.
// (RL13) Pre-event buffer shifts, keeping newest samples.
// (RL14) Trigger locked until buffer full, armed.
// (RL15) Pre-event beyond depth triggers at depth.
// (RL16) Trigger point is time zero.
// (RL17) Record at most 480000 samples total.
// (RL18) Without forced trigger, wait indefinitely.
// (RL19) Forced trigger after record-depth time.
// (RL20) Generator mode waits for sync plus delays.
// (RL21) Multichannel disables generator sync source.
// (RL22) Decimate every nth or peak of n.
// (RL23) Evaluate once per valid sample strobe.
`timescale 1ns/100ps
module wct_trigger
   import wct_pkg::*;
#(
   parameter int SW = 24,
   parameter int NCH = 8,
   parameter int PRE_DEPTH = 16,
   parameter int REC_DEPTH = WCT_REC_DEPTH,
   parameter int MUTE_CYC = WCT_MUTE_CYC,
   parameter int GEN_DELAY = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sample_valid,
   input wire logic signed [SW-1:0] ch1_sample,
   input wire logic signed [SW-1:0] ch2_sample,
   input wire logic signed [SW-1:0] tch_sample,
   input wire logic gen_sync,
   output logic gen_mute,
   output logic rec_valid,
   output logic signed [SW-1:0] rec_sample,
   output logic signed [31:0] rec_time,
   output logic [NCH-1:0] chan_enable
);
   initial begin
      if (PRE_DEPTH < 1 || PRE_DEPTH > WCT_PRE_DEPTH || REC_DEPTH < PRE_DEPTH || NCH < 2 || NCH > 16 || SW > 32) begin
         $error("wct_trigger: unsupported parameters");
      end
   end

   localparam int PW = $clog2(PRE_DEPTH + 1);

   typedef struct packed {
      logic awdone;
      logic [7:0] awaddr;
      logic wdone;
      logic [31:0] wdata;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic slope_fall;
      logic auto_en;
      logic dspec;
      logic multi;
      logic [2:0] src_sel;
      logic [1:0] mode;
      logic [3:0] tch;
      logic signed [SW-1:0] level;
      logic [31:0] pre_len;
      logic [31:0] depth;
      logic [15:0] fact;
      logic [NCH-1:0] chen;
      wct_state_t st;
      logic armed;
      logic [31:0] cnt;
      logic [31:0] tot;
      logic [PW-1:0] fill;
      logic [15:0] dcnt;
      logic signed [SW-1:0] peak;
      logic triggered;
      logic forced;
      logic signed [31:0] stamp;
      logic sync1;
      logic sync2;
      logic sync3;
      logic rvld;
      logic signed [SW-1:0] rsmp;
      logic signed [31:0] rtime;
   } wct_state_s_t;

   wct_state_s_t q, d;
   logic signed [SW-1:0] pre_q [PRE_DEPTH];

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Effective source after forcing conditions.
   wct_src_t eff_src;
   always_comb begin
      eff_src = wct_src_t'(q.src_sel);
      // (RL21) Generator sync unavailable
      if (q.multi && eff_src == WCT_SRC_GEN) begin
         eff_src = WCT_SRC_TCH;
      end
      // (RL3) Manual without channel
      if (q.multi && eff_src == WCT_SRC_TCH && !q.chen[q.tch[$clog2(NCH)-1:0]]) begin
         eff_src = WCT_SRC_MAN;
      end
      // (RL2) Spectrum forces manual
      if (q.dspec) begin
         eff_src = WCT_SRC_MAN;
      end
   end

   logic signed [SW-1:0] trig_smp;
   always_comb begin
      unique case (eff_src)
         WCT_SRC_CH1: trig_smp = ch1_sample;
         WCT_SRC_CH2: trig_smp = ch2_sample;
         default: trig_smp = tch_sample;
      endcase
   end

   // (RL9) Rising fires above level
   // (RL10) Falling fires below level
   logic above, below, fire_cond, arm_cond;
   assign above = trig_smp > q.level;
   assign below = trig_smp < q.level;
   assign fire_cond = q.slope_fall ? below : above;
   assign arm_cond = q.slope_fall ? above : below;

   logic wr_go, rd_go, stored, peak_out, ctl_cmd;
   logic signed [SW-1:0] store_val;
   logic [31:0] limit;
   assign wr_go = q.awdone && q.wdone && !q.bvalid;
   assign ctl_cmd = wr_go && q.awaddr == WCT_CTRL_ADDR && (q.wdata[WCT_CTRL_STOP] || q.wdata[WCT_CTRL_START]);
   assign rd_go = s_axi_arvalid && !q.rvalid;
   assign peak_out = q.dcnt + 16'h0001 >= q.fact;
   // (RL22) Decimation and peak keeping
   assign stored = sample_valid && (q.mode == WCT_MODE_STD || peak_out);
   assign store_val = (q.mode == WCT_MODE_PEAK) ? ((trig_smp > q.peak || q.dcnt == 16'h0000) ? trig_smp : q.peak)
      : trig_smp;
   // (RL17) Record limited to maximum
   assign limit = (q.depth > REC_DEPTH[31:0]) ? REC_DEPTH[31:0] : q.depth;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [31:0] pl;
      pl = (q.pre_len > PRE_DEPTH[31:0]) ? PRE_DEPTH[31:0] : q.pre_len;
      d = q;
      d.rvld = 1'b0;
      d.sync1 = gen_sync;
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;
      // Register bus.
      if (s_axi_awvalid && !q.awdone) begin
         d.awdone = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.wdone) begin
         d.wdone = 1'b1;
         d.wdata = merge(WCT_ZERO32, s_axi_wdata, s_axi_wstrb);
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (wr_go) begin
         d.awdone = 1'b0;
         d.wdone = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = WCT_RESP_OKAY;
         unique case (q.awaddr)
            WCT_CTRL_ADDR: begin
               d.slope_fall = q.wdata[WCT_CTRL_SLOPE];
               d.auto_en = q.wdata[WCT_CTRL_AUTO];
               d.dspec = q.wdata[WCT_CTRL_DSPEC];
               d.multi = q.wdata[WCT_CTRL_MULTI];
               d.src_sel = q.wdata[WCT_CTRL_SRC_LSB +: 3];
               d.mode = q.wdata[WCT_CTRL_MODE_LSB +: 2];
               d.tch = q.wdata[WCT_CTRL_TCH_LSB +: 4];
               // (RL1) Activate chosen channel
               d.chen[q.wdata[WCT_CTRL_TCH_LSB +: $clog2(NCH)]] = 1'b1;
            end
            WCT_LEVEL_ADDR: d.level = q.wdata[SW-1:0];
            WCT_PRE_ADDR: d.pre_len = q.wdata;
            WCT_DEPTH_ADDR: d.depth = q.wdata;
            WCT_CHEN_ADDR: d.chen = q.wdata[NCH-1:0];
            WCT_FACT_ADDR: d.fact = (q.wdata[15:0] == 16'h0000) ? 16'h0001 : q.wdata[15:0];
            default: d.bresp = WCT_RESP_SLVERR;
         endcase
      end
      if (rd_go) begin
         d.rvalid = 1'b1;
         d.rresp = WCT_RESP_OKAY;
         unique case (s_axi_araddr)
            WCT_CTRL_ADDR: d.rdata = {12'h000, q.tch, 2'b00, q.mode, 1'b0, q.src_sel, 2'b00, q.multi, q.dspec,
               q.auto_en, q.slope_fall, 2'b00};
            WCT_LEVEL_ADDR: d.rdata = 32'(q.level);
            WCT_PRE_ADDR: d.rdata = q.pre_len;
            WCT_DEPTH_ADDR: d.rdata = q.depth;
            WCT_STATUS_ADDR: d.rdata = {22'h000000, eff_src, q.forced, q.triggered, q.armed, 1'b0, 3'(q.st)};
            WCT_STAMP_ADDR: d.rdata = q.stamp;
            WCT_CHEN_ADDR: d.rdata = 32'(q.chen);
            WCT_FACT_ADDR: d.rdata = {16'h0000, q.fact};
            default: begin
               d.rdata = WCT_ZERO32;
               d.rresp = WCT_RESP_SLVERR;
            end
         endcase
      end
      // Capture machine.
      unique case (q.st)
         WCT_IDLE: ;
         WCT_FILL: begin
            if (eff_src == WCT_SRC_GEN) begin
               // (RL6) Mute and restart generator
               d.st = WCT_MUTE;
               d.cnt = WCT_ZERO32;
            // (RL23) Per valid strobe
            end else if (stored) begin
               d.tot = q.tot + WCT_ONE32;
               // (RL13) Shift pre-event fill
               if (32'(q.fill) < pl) begin
                  d.fill = q.fill + PW'(1);
               end
               // (RL8) Arm on opposite side
               if (arm_cond) begin
                  d.armed = 1'b1;
               end
               // (RL5) Manual fires at start
               if (eff_src == WCT_SRC_MAN) begin
                  d.triggered = 1'b1;
               // (RL11) (RL14) Locked until full and armed
               end else if ((32'(q.fill) >= pl) && q.armed && fire_cond) begin
                  d.triggered = 1'b1;
               // (RL15) (RL19) Depth reached
               end else if (q.tot + WCT_ONE32 >= limit && (q.auto_en || q.pre_len > limit)) begin
                  d.triggered = 1'b1;
                  d.forced = q.auto_en;
               end
               // (RL18) Otherwise keep waiting
               if (d.triggered) begin
                  // (RL15) (RL17) Full depth leaves no post
                  d.st = (32'(d.fill) >= limit) ? WCT_DONE : WCT_POST;
                  d.armed = 1'b0;
                  d.cnt = 32'(d.fill);
                  // (RL16) Pre-event gets negative time
                  d.stamp = -32'(d.fill);
               end
            end
         end
         WCT_MUTE: begin
            d.cnt = q.cnt + WCT_ONE32;
            if (q.cnt + WCT_ONE32 >= MUTE_CYC[31:0]) begin
               d.st = WCT_WAIT;
               d.cnt = WCT_ZERO32;
            end
         end
         WCT_WAIT: begin
            // (RL20) Sync pulse then delays
            if (q.sync2 && !q.sync3 && q.cnt == WCT_ZERO32) begin
               d.cnt = WCT_ONE32;
            end else if (q.cnt != WCT_ZERO32) begin
               d.cnt = q.cnt + WCT_ONE32;
               // (RL7) No filter settling wait
               if (q.cnt >= GEN_DELAY[31:0]) begin
                  d.st = WCT_POST;
                  d.triggered = 1'b1;
                  d.cnt = WCT_ZERO32;
                  d.stamp = WCT_ZERO32;
               end
            end
         end
         WCT_POST: begin
            if (stored) begin
               // (RL17) Post portion shortened
               d.cnt = q.cnt + WCT_ONE32;
               d.rvld = 1'b1;
               d.rsmp = store_val;
               d.rtime = q.cnt - 32'(q.fill);
               if (q.cnt + WCT_ONE32 >= limit) begin
                  d.st = WCT_DONE;
               end
            end
         end
         WCT_DONE: ;
         default: d.st = WCT_IDLE;
      endcase
      if (sample_valid) begin
         d.dcnt = peak_out ? 16'h0000 : q.dcnt + 16'h0001;
         d.peak = peak_out ? trig_smp : store_val;
      end
      // A start or stop command overrides the next state the capture machine chose.
      if (ctl_cmd) begin
         if (q.wdata[WCT_CTRL_STOP]) begin
            d.st = WCT_IDLE;
         end else begin
            d.st = WCT_FILL;
            d.fill = '0;
            d.tot = WCT_ZERO32;
            d.cnt = WCT_ZERO32;
            d.dcnt = 16'h0000;
            d.armed = 1'b0;
            d.triggered = 1'b0;
            d.forced = 1'b0;
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.st <= WCT_IDLE;
         q.src_sel <= 3'(WCT_SRC_MAN);
         q.fact <= 16'h0001;
         q.depth <= REC_DEPTH[31:0];
      end else begin
         q <= d;
      end
   end

   // (RL12) Pre-event shift register
   always_ff @(posedge aclk) begin
      if (q.st == WCT_FILL && stored) begin
         pre_q[0] <= store_val;
         for (int i = 1; i < PRE_DEPTH; i++) begin
            pre_q[i] <= pre_q[i-1];
         end
      end
   end

   assign s_axi_awready = !q.awdone;
   assign s_axi_wready = !q.wdone;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign gen_mute = q.st == WCT_MUTE;
   assign rec_valid = q.rvld;
   assign rec_sample = q.rsmp;
   assign rec_time = q.rtime;
   assign chan_enable = q.chen;

   // ****************************************
   // Checks
   // ****************************************
   // (RL2) Forced manual
   dspec_manual_a: assert property (@(posedge aclk) disable iff (!aresetn) q.dspec |-> eff_src == WCT_SRC_MAN)
      else $error("spectrum option did not force manual");
   // (RL6) Mute length
   mute_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (gen_mute && !ctl_cmd && q.cnt + WCT_ONE32 < MUTE_CYC[31:0]) |=> gen_mute) else $error("mute too short");
   // (RL14) Lock until armed
   trig_locked_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.st == WCT_FILL && !q.armed && eff_src != WCT_SRC_MAN && !q.auto_en && q.pre_len <= limit) |=> !q.triggered)
      else $error("trigger fired while unarmed");
   // (RL17) Record bound
   rec_bound_a: assert property (@(posedge aclk) disable iff (!aresetn) q.st == WCT_POST |-> q.cnt < limit)
      else $error("record exceeded depth");
   // (RL16) Stamp non-positive
   stamp_sign_a: assert property (@(posedge aclk) disable iff (!aresetn) q.stamp <= 0)
      else $error("trigger stamp positive");
   // (RL1) Channel activated
   chan_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && q.awaddr == WCT_CTRL_ADDR) |=> chan_enable[$past(q.wdata[WCT_CTRL_TCH_LSB +: $clog2(NCH)])])
      else $error("trigger channel not activated");
   // (RL21) No generator source in multichannel
   multi_gen_a: assert property (@(posedge aclk) disable iff (!aresetn) q.multi |-> eff_src != WCT_SRC_GEN)
      else $error("generator source in multichannel");
   // (RL5) Manual fires on first sample
   man_fire_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.st == WCT_FILL && eff_src == WCT_SRC_MAN && stored && !ctl_cmd) |=> q.triggered && q.st != WCT_FILL)
      else $error("manual did not fire");
endmodule

// ---- verification/wct_partner.sv ----
// Far-side model: measurement channel sample streams and generator sync source.
`timescale 1ns/100ps
module wct_partner
   import wct_pkg::*;
#(
   parameter int SW = 24,
   parameter int SYNC_LAG = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic signed [SW-1:0] v1,
   input wire logic signed [SW-1:0] v2,
   input wire logic signed [SW-1:0] vt,
   input wire logic gen_mute,
   output logic sample_valid,
   output logic signed [SW-1:0] ch1_sample,
   output logic signed [SW-1:0] ch2_sample,
   output logic signed [SW-1:0] tch_sample,
   output logic gen_sync
);
   logic mute_q;
   int lag;

   always @(posedge aclk) begin
      if (!aresetn) begin
         sample_valid <= 1'b0;
         ch1_sample <= '0;
         ch2_sample <= '0;
         tch_sample <= '0;
         gen_sync <= 1'b0;
         mute_q <= 1'b0;
         lag <= 0;
      end else begin
         sample_valid <= run;
         // Outside a run the lines toggle so stale values are never mistaken for data.
         if (run) begin
            ch1_sample <= v1;
            ch2_sample <= v2;
            tch_sample <= vt;
         end else begin
            ch1_sample <= ~ch1_sample;
            ch2_sample <= ~ch2_sample;
            tch_sample <= ~tch_sample;
         end
         mute_q <= gen_mute;
         if (mute_q && !gen_mute) begin
            lag <= SYNC_LAG + 2;
         end else if (lag != 0) begin
            lag <= lag - 1;
         end
         gen_sync <= (lag == 2) || (lag == 1);
      end
   end
endmodule

// ---- verification/waveform_capture_trigger_bench.sv ----
// Self-checking testbench for the waveform capture trigger.
`timescale 1ns/100ps
module waveform_capture_trigger_bench
   import wct_pkg::*;
;
   localparam int SW = 24;
   localparam int MUTE = 20;
   localparam int RDEP = 64;
   logic aclk, aresetn, run;
   logic [7:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, sample_valid, gen_sync, gen_mute, rec_valid;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   logic signed [SW-1:0] v1, v2, vt, ch1_sample, ch2_sample, tch_sample, rec_sample, first_s;
   logic signed [31:0] rec_time, first_t;
   logic [7:0] chan_enable;
   logic sync_seen;
   int miscompares, comparisons, rec_cnt, mute_cnt, early, gap, idle;

   wct_trigger #(.SW(SW), .NCH(8), .PRE_DEPTH(16), .REC_DEPTH(RDEP), .MUTE_CYC(MUTE), .GEN_DELAY(8)) wct_trigger_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sample_valid(sample_valid), .ch1_sample(ch1_sample),
      .ch2_sample(ch2_sample), .tch_sample(tch_sample), .gen_sync(gen_sync), .gen_mute(gen_mute),
      .rec_valid(rec_valid), .rec_sample(rec_sample), .rec_time(rec_time), .chan_enable(chan_enable));

   wct_partner #(.SW(SW), .SYNC_LAG(3)) wct_partner_i (
      .aclk(aclk), .aresetn(aresetn), .run(run), .v1(v1), .v2(v2), .vt(vt), .gen_mute(gen_mute),
      .sample_valid(sample_valid), .ch1_sample(ch1_sample), .ch2_sample(ch2_sample),
      .tch_sample(tch_sample), .gen_sync(gen_sync));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ****************************************
   // Output monitor
   // ****************************************
   always @(posedge aclk) begin
      if (gen_mute) mute_cnt++;
      if (gen_sync) sync_seen = 1'b1;
      if (rec_valid) begin
         if (rec_cnt == 0) begin
            first_s = rec_sample;
            first_t = rec_time;
         end
         if (!sync_seen) early++;
         rec_cnt++;
         gap = idle;
         idle = 0;
      end else begin
         idle++;
      end
   end

   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task complete_run;
      if (miscompares == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && n < 1000);
      r = bresp;
      bready <= 1'b0;
      if (n >= 1000) chk("bvalid", 32'h1, 32'h0);
   endtask

   task rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 1000);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 1000) chk("rvalid", 32'h1, 32'h0);
   endtask

   task wrr(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, rsp);
      chk("bresp", 32'(WCT_RESP_OKAY), 32'(rsp));
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] s, input logic fall, input logic au, input logic ds,
                                      input logic mu, input logic [3:0] tc);
      ctl = {12'h000, tc, 4'h0, 1'b0, s, 2'b00, mu, ds, au, fall, 2'b00};
   endfunction

   task cap(input logic [31:0] c, input logic [31:0] pre, input logic [31:0] dep);
      wrr(WCT_CTRL_ADDR, 32'h0000_0002);
      wrr(WCT_PRE_ADDR, pre);
      wrr(WCT_DEPTH_ADDR, dep);
      rec_cnt = 0;
      wrr(WCT_CTRL_ADDR, c | 32'h0000_0001);
   endtask

   task wait_for(input int n);
      int k;
      k = 0;
      while (rec_cnt < n && k < 400) begin
         @(posedge aclk);
         k++;
      end
      repeat (10) @(posedge aclk);
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready, run} = '0;
      wstrb = 4'hf;
      {v1, v2, vt} = '0;
      sync_seen = 1'b1;
      {miscompares, comparisons, rec_cnt, mute_cnt, early, gap, idle} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(WCT_STATUS_ADDR, rd, rsp);
      chk("state", 32'(WCT_IDLE), 32'(rd[2:0]));
      chk("eff_src", 32'(WCT_SRC_MAN), 32'(rd[9:7]));
      rdr(WCT_FACT_ADDR, rd, rsp);
      chk("factor", WCT_ONE32, rd);
      rdr(WCT_DEPTH_ADDR, rd, rsp);
      chk("depth", 32'(RDEP), rd);
      rdr(8'h20, rd, rsp);
      chk("rresp", 32'(WCT_RESP_SLVERR), 32'(rsp));
      chk("rdata", WCT_ZERO32, rd);
      wr(8'h24, 32'h1234_5678, rsp);
      chk("bresp", 32'(WCT_RESP_SLVERR), 32'(rsp));
      run <= 1'b1;
      wrr(WCT_CHEN_ADDR, WCT_ZERO32);
      wrr(WCT_CTRL_ADDR, ctl(WCT_SRC_TCH, 1'b0, 1'b0, 1'b0, 1'b1, 4'h5));
      chk("tch_on", 32'h1, 32'(chan_enable[5]));
      wrr(WCT_CHEN_ADDR, WCT_ZERO32);
      rdr(WCT_STATUS_ADDR, rd, rsp);
      chk("no_tch_src", 32'(WCT_SRC_MAN), 32'(rd[9:7]));
      wrr(WCT_CTRL_ADDR, ctl(WCT_SRC_GEN, 1'b0, 1'b0, 1'b0, 1'b1, 4'h5));
      rdr(WCT_STATUS_ADDR, rd, rsp);
      chk("gen_src", 32'h0, 32'(rd[9:7] == WCT_SRC_GEN));
      wrr(WCT_CTRL_ADDR, ctl(WCT_SRC_CH1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0));
      rdr(WCT_STATUS_ADDR, rd, rsp);
      chk("dspec_src", 32'(WCT_SRC_MAN), 32'(rd[9:7]));
      cap(ctl(WCT_SRC_MAN, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0), WCT_ZERO32, 32'h8);
      wait_for(8);
      chk("man_count", 32'h8, 32'(rec_cnt));
      chk("man_time", WCT_ZERO32, first_t);
      rdr(WCT_STATUS_ADDR, rd, rsp);
      chk("done", 32'(WCT_DONE), 32'(rd[2:0]));
      wrr(WCT_LEVEL_ADDR, 32'h0000_0064);
      v1 <= 24'h0000c8;
      cap(ctl(WCT_SRC_CH1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0), WCT_ZERO32, 32'h6);
      repeat (20) @(posedge aclk);
      chk("rise_lock", 32'h0, 32'(rec_cnt));
      v1 <= 24'h000032;
      repeat (5) @(posedge aclk);
      v1 <= 24'h0000c8;
      wait_for(6);
      chk("rise_count", 32'h6, 32'(rec_cnt));
      chk("rise_first", 32'h0000_00c8, 32'(first_s));
      v2 <= 24'h000032;
      cap(ctl(WCT_SRC_CH2, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0), WCT_ZERO32, 32'h6);
      repeat (20) @(posedge aclk);
      chk("fall_lock", 32'h0, 32'(rec_cnt));
      v2 <= 24'h0000c8;
      repeat (5) @(posedge aclk);
      v2 <= 24'h000032;
      wait_for(6);
      chk("fall_count", 32'h6, 32'(rec_cnt));
      chk("fall_first", 32'h0000_0032, 32'(first_s));
      vt <= 24'h000032;
      cap(ctl(WCT_SRC_TCH, 1'b0, 1'b0, 1'b0, 1'b1, 4'h5), 32'h4, 32'h8);
      repeat (12) @(posedge aclk);
      vt <= 24'h0000c8;
      wait_for(4);
      chk("pre_count", 32'h4, 32'(rec_cnt));
      chk("pre_time", WCT_ZERO32, first_t);
      rdr(WCT_STAMP_ADDR, rd, rsp);
      chk("pre_stamp", 32'hffff_fffc, rd);
      v1 <= 24'h000032;
      cap(ctl(WCT_SRC_CH1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0), 32'hc, 32'h8);
      repeat (60) @(posedge aclk);
      rdr(WCT_STATUS_ADDR, rd, rsp);
      chk("long_pre", 32'h1, 32'(rd[5]));
      rdr(WCT_STAMP_ADDR, rd, rsp);
      chk("long_stamp", 32'hffff_fff8, rd);
      cap(ctl(WCT_SRC_CH1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0), WCT_ZERO32, 32'h8);
      repeat (100) @(posedge aclk);
      chk("no_auto", 32'h0, 32'(rec_cnt));
      cap(ctl(WCT_SRC_CH1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0), WCT_ZERO32, 32'h8);
      wait_for(8);
      chk("auto_count", 32'h8, 32'(rec_cnt));
      rdr(WCT_STATUS_ADDR, rd, rsp);
      chk("forced", 32'h1, 32'(rd[6]));
      wrr(WCT_FACT_ADDR, 32'h0000_0002);
      cap(ctl(WCT_SRC_MAN, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0) | 32'h0000_2000, WCT_ZERO32, 32'h4);
      wait_for(4);
      chk("dec_count", 32'h4, 32'(rec_cnt));
      chk("dec_gap", 32'h1, 32'(gap));
      wrr(WCT_CTRL_ADDR, 32'h0000_0002);
      sync_seen = 1'b0;
      mute_cnt = 0;
      cap(ctl(WCT_SRC_GEN, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0), WCT_ZERO32, 32'h8);
      wait_for(8);
      chk("mute_len", 32'(MUTE), 32'(mute_cnt));
      chk("early_rec", 32'h0, 32'(early));
      chk("gen_count", 32'h8, 32'(rec_cnt));
      complete_run;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      complete_run;
   end
endmodule
